// File: hw/wcd_decoder.sv
// wiper command decoder: frame parser on the link clock, registers on
// the system clock
// assumes: a bit-level slave on link_clk delivers start, stop and
// received bytes as one-cycle pulses; it drives the ack bit from lk_ack
//
// What this block does
// - first byte after the address is command, later bytes data
// - first data byte goes to selected register for live and stored writes; recall and save ignore it
// - four command codes; every byte of a selected frame acknowledged
// - live write loads wiper immediately
// - stored write leaves wiper alone
// - recall copies stored into live wiper
// - save copies live into stored register
// - stored register is 8 bits, survives reset
// - stored register starts at midscale
// - power-up recall finishes within 10 us
// - standby whenever power-up is done and no transaction runs
// - address is 0101, factory bits, pin bit
// - acknowledge address hits and each later byte of a selected frame
`timescale 1ns/1ps
`default_nettype none
`include "wcd_map.svh"

module wcd_decoder
    import wcd_pkg::*;
#(
    parameter logic [1:0] FACTORY_BITS = 2'b00,
    parameter int         INIT_CYC     = `WCD_INIT_CYC
) (
    input  wire logic       clk_sys,
    input  wire logic       rst,
    input  wire logic       nv_factory_rst,
    input  wire logic       link_clk,
    input  wire logic       addr_select_pin,
    input  wire logic       lk_start,
    input  wire logic       lk_stop,
    input  wire logic       lk_byte_valid,
    input  wire logic [7:0] lk_byte,
    output logic            lk_ack,
    output logic      [7:0] wiper_pos,
    output logic      [7:0] stored_pos,
    output logic            init_done,
    output logic            standby
);

    localparam int CW = $clog2(INIT_CYC + 1);
    localparam logic [CW-1:0] INIT_LAST = CW'(INIT_CYC - 1);

    // ---------------- link domain ----------------
    logic            lk_rst_s1_q;
    logic            lk_rst_q;
    logic            a0_s1_q;
    logic            a0_s2_q;
    wcd_link_t       phase_q;
    logic [7:0]      cmd_q;
    logic [7:0]      req_cmd_q;
    logic [7:0]      req_data_q;
    logic            req_tgl_q;
    logic            lk_ack_q;
    logic            lk_busy_q;
    logic            addr_hit;
    logic            write_bit;
    logic            cmd_ok;

    // link reset: asserted at once, released on the link clock
    always_ff @(posedge link_clk or posedge rst) begin
        if (rst) begin
            lk_rst_s1_q <= 1'b1;
            lk_rst_q    <= 1'b1;
        end else begin
            lk_rst_s1_q <= 1'b0;
            lk_rst_q    <= lk_rst_s1_q;
        end
    end

    // address pin synchronised before use
    always_ff @(posedge link_clk or posedge lk_rst_q) begin
        if (lk_rst_q) begin
            a0_s1_q <= 1'b0;
            a0_s2_q <= 1'b0;
        end else begin
            a0_s1_q <= addr_select_pin;
            a0_s2_q <= a0_s1_q;
        end
    end

    assign addr_hit  = lk_byte[7:4] == `WCD_ADDR_HI
                    && lk_byte[3:2] == FACTORY_BITS
                    && lk_byte[1] == a0_s2_q;
    assign write_bit = ~lk_byte[0];
    assign cmd_ok    = cmd_q == `WCD_CMD_LIVE
                    || cmd_q == `WCD_CMD_STORED
                    || cmd_q == `WCD_CMD_RECALL
                    || cmd_q == `WCD_CMD_SAVE;

    // frame position
    always_ff @(posedge link_clk or posedge lk_rst_q) begin
        if (lk_rst_q) begin
            phase_q <= WCD_LK_IDLE;
        end else if (lk_stop) begin
            phase_q <= WCD_LK_IDLE;
        end else if (lk_start) begin
            phase_q <= WCD_LK_ADDR;
        end else if (lk_byte_valid) begin
            unique case (phase_q)
                WCD_LK_IDLE: begin
                    phase_q <= WCD_LK_IDLE;
                end
                WCD_LK_ADDR: begin
                    if (addr_hit && write_bit) begin
                        phase_q <= WCD_LK_CMD;
                    end else begin
                        phase_q <= WCD_LK_IDLE;
                    end
                end
                WCD_LK_CMD: begin
                    phase_q <= WCD_LK_DATA;
                end
                WCD_LK_DATA: begin
                    phase_q <= WCD_LK_MORE;
                end
                WCD_LK_MORE: begin
                    phase_q <= WCD_LK_MORE;
                end
            endcase
        end
    end

    // command byte capture
    always_ff @(posedge link_clk or posedge lk_rst_q) begin
        if (lk_rst_q) begin
            cmd_q <= 8'h00;
        end else if (lk_byte_valid && phase_q == WCD_LK_CMD
                     && !lk_start && !lk_stop) begin
            cmd_q <= lk_byte;
        end
    end

    // first data byte of a known command becomes a request
    always_ff @(posedge link_clk or posedge lk_rst_q) begin
        if (lk_rst_q) begin
            req_cmd_q  <= 8'h00;
            req_data_q <= 8'h00;
            req_tgl_q  <= 1'b0;
        end else if (lk_byte_valid && phase_q == WCD_LK_DATA
                     && !lk_start && !lk_stop && cmd_ok) begin
            req_cmd_q  <= cmd_q;
            req_data_q <= lk_byte;
            req_tgl_q  <= ~req_tgl_q;
        end
    end

    // acknowledge address hits and every byte of a selected frame
    always_ff @(posedge link_clk or posedge lk_rst_q) begin
        if (lk_rst_q) begin
            lk_ack_q <= 1'b0;
        end else if (lk_byte_valid && !lk_start && !lk_stop) begin
            unique case (phase_q)
                WCD_LK_ADDR: lk_ack_q <= addr_hit;
                WCD_LK_CMD:  lk_ack_q <= 1'b1;
                WCD_LK_DATA: lk_ack_q <= 1'b1;
                WCD_LK_MORE: lk_ack_q <= 1'b1;
                WCD_LK_IDLE: lk_ack_q <= 1'b0;
            endcase
        end else begin
            lk_ack_q <= 1'b0;
        end
    end

    // frame in progress, for standby
    always_ff @(posedge link_clk or posedge lk_rst_q) begin
        if (lk_rst_q) begin
            lk_busy_q <= 1'b0;
        end else begin
            lk_busy_q <= phase_q != WCD_LK_IDLE;
        end
    end

    assign lk_ack = lk_ack_q;

    // ---------------- system domain ----------------
    wcd_sys_t        state_q;
    logic [CW-1:0]   cnt_q;
    logic            tgl_s1_q;
    logic            tgl_s2_q;
    logic            seen_q;
    logic            busy_s1_q;
    logic            busy_s2_q;
    logic [7:0]      live_q;
    logic            init_done_q;
    logic            standby_q;
    logic            exec_w;
    logic            nv_we;
    logic [7:0]      nv_wdata;
    logic [7:0]      nv_rdata;

    // request toggle and busy level cross on two flops each
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            tgl_s1_q  <= 1'b0;
            tgl_s2_q  <= 1'b0;
            busy_s1_q <= 1'b0;
            busy_s2_q <= 1'b0;
        end else begin
            tgl_s1_q  <= req_tgl_q;
            tgl_s2_q  <= tgl_s1_q;
            busy_s1_q <= lk_busy_q;
            busy_s2_q <= busy_s1_q;
        end
    end

    // requests wait out the power-up window; only one pending request is held
    assign exec_w = state_q == WCD_RUN && tgl_s2_q != seen_q;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            seen_q <= 1'b0;
        end else if (exec_w) begin
            seen_q <= tgl_s2_q;
        end
    end

    // power-up recall window
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state_q <= WCD_INIT;
            cnt_q   <= '0;
        end else begin
            unique case (state_q)
                WCD_INIT: begin
                    cnt_q <= cnt_q + CW'(1);
                    if (cnt_q == INIT_LAST) begin
                        state_q <= WCD_RUN;
                    end
                end
                WCD_RUN: begin
                    state_q <= WCD_RUN;
                end
            endcase
        end
    end

    // live register, drives the wiper
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            live_q <= 8'h00;
        end else if (state_q == WCD_INIT) begin
            live_q <= nv_rdata;
        end else if (exec_w && req_cmd_q == `WCD_CMD_LIVE) begin
            live_q <= req_data_q;
        end else if (exec_w && req_cmd_q == `WCD_CMD_RECALL) begin
            live_q <= nv_rdata;
        end
    end

    assign nv_we    = exec_w && (req_cmd_q == `WCD_CMD_STORED
                              || req_cmd_q == `WCD_CMD_SAVE);
    assign nv_wdata = req_cmd_q == `WCD_CMD_SAVE ? live_q
                                                 : req_data_q;

    wcd_nv_reg u_nv (
        .clk     (clk_sys),
        .nv_rst  (nv_factory_rst),
        .we      (nv_we),
        .wdata   (nv_wdata),
        .rdata_q (nv_rdata)
    );

    // status flags
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            init_done_q <= 1'b0;
            standby_q   <= 1'b0;
        end else begin
            init_done_q <= state_q == WCD_RUN;
            standby_q   <= state_q == WCD_RUN && !busy_s2_q
                        && !exec_w;
        end
    end

    assign wiper_pos  = live_q;
    assign stored_pos = nv_rdata;
    assign init_done  = init_done_q;
    assign standby    = standby_q;

    // ---------------- checks ----------------
    sequence run_cmd_s(logic [7:0] c);
        exec_w && req_cmd_q == c;
    endsequence

    sequence addr_write_s;
        lk_byte_valid && !lk_start && !lk_stop && phase_q == WCD_LK_ADDR
            && addr_hit && write_bit;
    endsequence

    init_recall_a: assert property (@(posedge clk_sys)
        disable iff (rst) state_q == WCD_INIT && cnt_q == INIT_LAST
        |=> state_q == WCD_RUN && live_q == $past(nv_rdata)
            ##1 init_done_q)
        else $error("power-up recall did not end on time");

    live_write_a: assert property (@(posedge clk_sys)
        disable iff (rst) run_cmd_s(`WCD_CMD_LIVE)
        |=> live_q == $past(req_data_q) && nv_rdata == $past(nv_rdata))
        else $error("live write did not move the wiper");

    stored_write_a: assert property (@(posedge clk_sys)
        disable iff (rst) run_cmd_s(`WCD_CMD_STORED)
        |=> nv_rdata == $past(req_data_q) && $stable(live_q))
        else $error("stored write wrong or wiper moved");

    recall_copy_a: assert property (@(posedge clk_sys)
        disable iff (rst) run_cmd_s(`WCD_CMD_RECALL)
        |=> live_q == $past(nv_rdata))
        else $error("recall did not copy stored value");

    save_copy_a: assert property (@(posedge clk_sys)
        disable iff (rst) run_cmd_s(`WCD_CMD_SAVE)
        |=> nv_rdata == $past(live_q) && $stable(live_q))
        else $error("save did not copy live value");

    standby_idle_a: assert property (@(posedge clk_sys)
        disable iff (rst) busy_s2_q |=> !standby_q)
        else $error("standby raised during a frame");

    standby_enter_a: assert property (@(posedge clk_sys)
        disable iff (rst) (state_q == WCD_RUN && !busy_s2_q && !exec_w)[*2]
        |-> standby_q)
        else $error("standby not entered when idle");

    cmd_follows_a: assert property (@(posedge link_clk)
        disable iff (lk_rst_q)
        addr_write_s |=> phase_q == WCD_LK_CMD && lk_ack_q)
        else $error("command byte not expected after address");

    addr_miss_a: assert property (@(posedge link_clk)
        disable iff (lk_rst_q) lk_byte_valid && !lk_start && !lk_stop
            && phase_q == WCD_LK_ADDR && !addr_hit
        |=> phase_q == WCD_LK_IDLE && !lk_ack_q)
        else $error("foreign address accepted");

    byte_ack_a: assert property (@(posedge link_clk)
        disable iff (lk_rst_q) lk_byte_valid && !lk_start && !lk_stop
            && (phase_q == WCD_LK_CMD || phase_q == WCD_LK_DATA)
        |=> lk_ack_q ##1 (!lk_ack_q || $past(lk_byte_valid)))
        else $error("received byte not acknowledged");

    bad_cmd_a: assert property (@(posedge link_clk)
        disable iff (lk_rst_q) lk_byte_valid && phase_q == WCD_LK_DATA
            && !cmd_ok |=> $stable(req_tgl_q))
        else $error("unknown command produced a request");

    first_data_a: assert property (@(posedge link_clk)
        disable iff (lk_rst_q) phase_q == WCD_LK_MORE
        |=> $stable(req_tgl_q) && $stable(req_data_q))
        else $error("later data byte reached a register");

endmodule : wcd_decoder
`default_nettype wire

// File: hw/wcd_map.svh
// wiper command decoder: addresses, command codes, reset values, timing
// assumes: included by bare name from the design files and the bench
`ifndef WCD_MAP_SVH
`define WCD_MAP_SVH

// fixed upper nibble of the seven-bit slave address
`define WCD_ADDR_HI      4'h5
// command byte codes
`define WCD_CMD_LIVE     8'h11
`define WCD_CMD_STORED   8'h21
`define WCD_CMD_RECALL   8'h61
`define WCD_CMD_SAVE     8'h51
// stored register value as delivered
`define WCD_MIDSCALE     8'h80
// power-up recall window, longest time, rounded down to cycles
`define WCD_INIT_NS      10000
`define WCD_CLK_NS       5
`define WCD_INIT_CYC     (`WCD_INIT_NS / `WCD_CLK_NS)

`endif

// File: hw/wcd_pkg.sv
// wiper command decoder: state types
// assumes: nothing beyond the constants header
`default_nettype none

package wcd_pkg;
    // system side: power-up recall, then normal operation
    typedef enum logic [1:0] {
        WCD_INIT = 2'b01,
        WCD_RUN  = 2'b10
    } wcd_sys_t;

    // link side: position within one write frame
    typedef enum logic [4:0] {
        WCD_LK_IDLE = 5'b00001,
        WCD_LK_ADDR = 5'b00010,
        WCD_LK_CMD  = 5'b00100,
        WCD_LK_DATA = 5'b01000,
        WCD_LK_MORE = 5'b10000
    } wcd_link_t;
endpackage : wcd_pkg
`default_nettype wire

// File: hw/wcd_nv_reg.sv
// wiper command decoder: the 8-bit stored wiper cell
// assumes: nv_rst only at manufacture; system reset never reaches it
`timescale 1ns/1ps
`default_nettype none
`include "wcd_map.svh"

module wcd_nv_reg
    import wcd_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       nv_rst,
    input  wire logic       we,
    input  wire logic [7:0] wdata,
    output logic      [7:0] rdata_q
);

    // holds across system reset; only a write or nv_rst changes it
    always_ff @(posedge clk or posedge nv_rst) begin
        if (nv_rst) begin
            rdata_q <= `WCD_MIDSCALE;
        end else if (we) begin
            rdata_q <= wdata;
        end
    end

    nv_factory_a: assert property (@(posedge clk)
        nv_rst |-> rdata_q == `WCD_MIDSCALE)
        else $error("stored cell not midscale in factory reset");

    nv_hold_a: assert property (@(posedge clk)
        disable iff (nv_rst) !we |=> rdata_q == $past(rdata_q))
        else $error("stored cell changed without a write");

endmodule : wcd_nv_reg
`default_nettype wire

// File: verification/wcd_link_master.sv
// link-side master model: start, bytes and stop as link_clk pulses
// assumes: caller waits for the device to finish between frames
`timescale 1ns/1ps
`default_nettype none

module wcd_link_master (
    input  wire logic       link_clk,
    output logic            lk_start,
    output logic            lk_stop,
    output logic            lk_byte_valid,
    output logic      [7:0] lk_byte
);
    initial begin
        lk_start      = 1'b0;
        lk_stop       = 1'b0;
        lk_byte_valid = 1'b0;
        lk_byte       = 8'h00;
    end

    // one link cycle per symbol; byte lines inverted while not valid
    task automatic sym(input logic s, input logic p, input logic v,
                       input logic [7:0] b);
        @(negedge link_clk);
        lk_start      <= s;
        lk_stop       <= p;
        lk_byte_valid <= v;
        lk_byte       <= v ? b : ~lk_byte;
    endtask : sym

    // write frame: address byte first, then the rest, then stop
    task automatic frame(input logic [7:0] bytes[$]);
        sym(1'b1, 1'b0, 1'b0, 8'h00);
        foreach (bytes[i]) sym(1'b0, 1'b0, 1'b1, bytes[i]);
        sym(1'b0, 1'b1, 1'b0, 8'h00);
        sym(1'b0, 1'b0, 1'b0, 8'h00);
    endtask : frame
endmodule : wcd_link_master
`default_nettype wire

// File: verification/tb_wiper_command_decoder.sv
// self-checking bench for the wiper command decoder
// assumes: the link master model drives the link side
`timescale 1ns/1ps
`default_nettype none
`include "wcd_map.svh"

module tb_wiper_command_decoder;
    localparam int         INIT_N = 8;
    localparam logic [1:0] FB     = 2'b00;
    logic        clk_sys  = 1'b1;
    logic        link_clk = 1'b0;
    logic        rst      = 1'b0;
    logic        nv_rst   = 1'b0;
    logic        pin      = 1'b0;
    logic        lk_start, lk_stop, lk_byte_valid, lk_ack;
    logic        init_done, standby;
    logic [7:0]  lk_byte, wiper_pos, stored_pos;
    logic [7:0]  exp_live, exp_stored;
    logic [7:0]  acks     = 8'h00;
    logic [23:0] exp_q[$];
    logic [7:0]  cmds[7];
    int          error_cnt  = 0;
    int          num_checks = 0;
    int          cyc        = 0;

    always #2.5 clk_sys = ~clk_sys;
    initial begin
        #1.3;
        forever #7.5 link_clk = ~link_clk;
    end

    wcd_decoder #(.FACTORY_BITS(FB), .INIT_CYC(INIT_N)) dut (
        .clk_sys        (clk_sys),
        .rst            (rst),
        .nv_factory_rst (nv_rst),
        .link_clk       (link_clk),
        .addr_select_pin(pin),
        .lk_start       (lk_start),
        .lk_stop        (lk_stop),
        .lk_byte_valid  (lk_byte_valid),
        .lk_byte        (lk_byte),
        .lk_ack         (lk_ack),
        .wiper_pos      (wiper_pos),
        .stored_pos     (stored_pos),
        .init_done      (init_done),
        .standby        (standby)
    );

    wcd_link_master u_mst (
        .link_clk     (link_clk),
        .lk_start     (lk_start),
        .lk_stop      (lk_stop),
        .lk_byte_valid(lk_byte_valid),
        .lk_byte      (lk_byte)
    );

    always @(posedge link_clk) begin
        if (lk_ack === 1'b1) acks <= acks + 8'h01;
    end

    task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
        num_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic complete_run;
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : complete_run

    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            error_cnt++;
            complete_run();
        end
    end

    // result is taken two system cycles after standby comes back after a frame
    initial begin : watch
        logic        p;
        logic [23:0] e;
        p = 1'b0;
        forever begin
            @(negedge clk_sys);
            if (standby === 1'b1 && p === 1'b0 && exp_q.size() > 0) begin
                repeat (2) @(negedge clk_sys);
                e = exp_q.pop_front();
                chk({acks, wiper_pos, stored_pos}, e);
            end
            p = standby;
        end
    end

    task automatic power_up;
        int n;
        n = 1;
        exp_live = exp_stored;
        @(posedge clk_sys);
        #1;
        chk(24'(wiper_pos), 24'(exp_stored));
        while (init_done !== 1'b1 && n < 100) begin
            @(posedge clk_sys);
            #1;
            n++;
        end
        chk(24'(n), 24'(INIT_N + 1));
        repeat (10) @(negedge clk_sys);
        chk({7'h00, standby, wiper_pos, stored_pos},
            {8'h01, exp_stored, exp_stored});
    endtask : power_up

    task automatic run(input logic [7:0] a, input logic [7:0] c,
                       input logic [7:0] d, input int n);
        logic [7:0] q[$];
        logic [7:0] k;
        logic       hit;
        int         w;
        hit = (a[7:1] == {`WCD_ADDR_HI, FB, pin});
        q = '{a};
        k = hit ? 8'h01 : 8'h00;
        if (!a[0]) begin
            q.push_back(c);
            q.push_back(d);
            repeat (n) q.push_back(8'($urandom));
        end
        if (hit && !a[0]) begin
            k = 8'(q.size());
            case (c)
                `WCD_CMD_LIVE:   exp_live = d;
                `WCD_CMD_STORED: exp_stored = d;
                `WCD_CMD_RECALL: exp_live = exp_stored;
                `WCD_CMD_SAVE:   exp_stored = exp_live;
                default: ;
            endcase
        end
        exp_q.push_back({k, exp_live, exp_stored});
        @(negedge link_clk);
        acks = 8'h00;
        u_mst.frame(q);
        w = 0;
        while (exp_q.size() > 0 && w < 400) begin
            @(posedge clk_sys);
            w++;
        end
        if (exp_q.size() > 0) begin
            chk(24'(exp_q.size()), 24'h000000);
            exp_q.delete();
        end
    endtask : run

    initial begin
        void'($urandom(32'hc8f7d7a7));
        exp_stored = `WCD_MIDSCALE;
        cmds = '{`WCD_CMD_LIVE, `WCD_CMD_STORED, `WCD_CMD_RECALL,
                 `WCD_CMD_LIVE, `WCD_CMD_SAVE, 8'h31, 8'h01};
        // raise reset by an event so the async branches really run
        @(negedge clk_sys);
        rst    = 1'b1;
        nv_rst = 1'b1;
        repeat (10) @(negedge clk_sys);
        rst    = 1'b0;
        nv_rst = 1'b0;
        power_up();
        $display("test power_up done");
        foreach (cmds[i]) run(8'h50, cmds[i], 8'($urandom), i % 3);
        run(8'h50, `WCD_CMD_LIVE, 8'hff, 0);
        $display("test commands done");
        run(8'h51, `WCD_CMD_LIVE, 8'h3c, 0);
        run(8'h54, `WCD_CMD_LIVE, 8'h3c, 1);
        run(8'h52, `WCD_CMD_LIVE, 8'h3c, 0);
        @(negedge clk_sys);
        pin = 1'b1;
        repeat (10) @(negedge clk_sys);
        run(8'h52, `WCD_CMD_LIVE, 8'h00, 0);
        run(8'h50, `WCD_CMD_STORED, 8'h3c, 0);
        $display("test address done");
        run(8'h52, `WCD_CMD_STORED, 8'($urandom), 0);
        @(negedge clk_sys);
        rst = 1'b1;
        repeat (3) @(negedge clk_sys);
        rst = 1'b0;
        power_up();
        $display("test power_cycle done");
        complete_run();
    end
endmodule : tb_wiper_command_decoder
`default_nettype wire
